// ---- bench/csc_electrode_model.sv ----
// behavioural electrodes on the analog inputs, answering the sar comparator
module csc_electrode_model #(
  parameter logic [15:0] BASE = 16'h1234,
  parameter logic [15:0] INC = 16'h0111
) (
  input wire csc_pkg::csc_afe_s afe, // front-end controls from the block
  output logic cmp_pin // 1 keeps the trial bit
);
  logic [15:0] sum;
  // shorted channels add their capacitance; nothing selected reads as ground
  always_comb begin
    sum = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (afe.chan_sel[i]) begin
        sum = sum + BASE + INC * 16'(i);
      end
    end
    cmp_pin = afe.enable && (afe.chan_sel != 16'h0000) && (sum >= afe.trial);
  end
endmodule : csc_electrode_model

// ---- bench/test_capacitive_sense_conversion_control.sv ----
// register-level testbench of the capacitive sense conversion control
module test_capacitive_sense_conversion_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 6; // pin sync needs four edges, so each step must be at least five
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cmp_pin, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tmr_ovf;
  logic [15:0] m;
  csc_pkg::csc_afe_s afe;
  int n_mismatch, checks_done, cyc, n;
  logic [7:0] ra [10] = '{8'h40, 8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [31:0] rv [10] = '{0, 0, 0, 32'h71, 0, 0, 0, 0, 0, 0};
  int nb [4] = '{12, 13, 14, 16};
  int tid [4] = '{0, 2, 1, 3};

  // clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  assign hready = hreadyout; // single slave drives bus ready

  csc_top #(.STEP(STEP)) u_csc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tmr_ovf(tmr_ovf),
    .cmp_pin(cmp_pin), .afe(afe), .irq(irq));
  csc_electrode_model u_csc_electrode_model (.afe(afe), .cmp_pin(cmp_pin));

  // electrode value of one channel, as the model is built
  function automatic logic [15:0] cap(input int c);
    return 16'h1234 + 16'h0111 * 16'(c);
  endfunction : cap

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one ahb-lite single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
    check(32'(hresp), 32'h0);
  endtask : rdchk

  // poll busy until the final result is stored, bounded
  task automatic wait_idle;
    int k;
    k = 0;
    // run modes leave idle one cycle after the busy write lands
    @(posedge hclk);
    xfer(1'b0, csc_pkg::OFF_CTRL, 32'h0);
    while (rd[csc_pkg::CTRL_BUSY] !== 1'b0 && k < 2000) begin
      xfer(1'b0, csc_pkg::OFF_CTRL, 32'h0);
      k++;
    end
    check(32'(k < 2000), 32'h1);
  endtask : wait_idle

  // one-cycle timer overflow pulses
  task automatic pulse(input logic [3:0] v);
    tmr_ovf <= v;
    @(posedge hclk);
    tmr_ovf <= 4'h0;
    repeat (2) @(posedge hclk);
  endtask : pulse

  task automatic finish_test;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // hang guard, far above the few thousand cycles the tests need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, tmr_ovf} = '0;
    hsize = 3'h2;
    {n_mismatch, checks_done, cyc} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and an unmapped place that ignores writes
    xfer(1'b1, 8'h40, 32'hffffffff);
    for (int i = 0; i < 10; i++) rdchk(ra[i], rv[i]);
    check(32'(afe.gain), 32'(csc_pkg::GAIN_RST));
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h2);
    rdchk(csc_pkg::OFF_CTRL, 32'h0);
    // enable first, then start mode, then the rest
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h1);
    xfer(1'b1, csc_pkg::OFF_CFG, 32'h0);
    xfer(1'b1, csc_pkg::OFF_MUX, 32'h3);
    xfer(1'b1, csc_pkg::OFF_THRESH, 32'hffff);
    xfer(1'b1, csc_pkg::OFF_IRQ_MASK, 32'h7);
    check(32'(afe.chan_sel), 32'h8);
    // every conversion length, with the done interrupt raised and cleared
    for (int l = 0; l < 4; l++) begin
      m = 16'hffff << (16 - nb[l]);
      xfer(1'b1, csc_pkg::OFF_MODE2, 32'h70 | l);
      xfer(1'b1, csc_pkg::OFF_CTRL, 32'h3);
      rdchk(csc_pkg::OFF_CTRL, 32'h3);
      wait_idle();
      rdchk(csc_pkg::OFF_RESULT, 32'(cap(3) & m));
      check(32'(irq), 32'h1);
      xfer(1'b1, csc_pkg::OFF_IRQ_STAT, 32'h7);
      @(posedge hclk);
      check(32'(irq), 32'h0);
    end
    xfer(1'b1, csc_pkg::OFF_MODE2, 32'h21);
    @(posedge hclk);
    check(32'(afe.gain), 32'h2);
    // four-sample accumulation: one interrupt after all samples
    xfer(1'b1, csc_pkg::OFF_CFG, 32'h1);
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h3);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    check(32'(n >= 4 * 13 * STEP && n < 2000), 32'h1);
    rdchk(csc_pkg::OFF_RESULT, 32'(cap(3) & 16'hfff8));
    // greater flag above threshold, clear at equal
    xfer(1'b1, csc_pkg::OFF_CFG, 32'h0);
    for (int t = 0; t < 2; t++) begin
      xfer(1'b1, csc_pkg::OFF_IRQ_STAT, 32'h7);
      xfer(1'b1, csc_pkg::OFF_THRESH, 32'(cap(3) & 16'hfff8) - 32'(1 - t));
      xfer(1'b1, csc_pkg::OFF_CTRL, 32'h3);
      wait_idle();
      check(rd, t == 0 ? 32'h5 : 32'h1);
      rdchk(csc_pkg::OFF_IRQ_STAT, t == 0 ? 32'h3 : 32'h1);
    end
    // timer sources: wrong timers ignored, an overflow during a conversion ignored
    for (int s = 1; s < 5; s++) begin
      xfer(1'b1, csc_pkg::OFF_CFG, 32'(s) << 4);
      pulse(~(4'h1 << tid[s - 1]));
      rdchk(csc_pkg::OFF_CTRL, 32'h1);
      pulse(4'h1 << tid[s - 1]);
      rdchk(csc_pkg::OFF_CTRL, 32'h3);
      pulse(4'h1 << tid[s - 1]);
      wait_idle();
      repeat (10) @(posedge hclk);
      rdchk(csc_pkg::OFF_CTRL, 32'h1);
    end
    // continuous waits for busy, then repeats; disable aborts
    xfer(1'b1, csc_pkg::OFF_CFG, 32'h60);
    repeat (100) @(posedge hclk);
    rdchk(csc_pkg::OFF_CTRL, 32'h1);
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h3);
    repeat (200) @(posedge hclk);
    xfer(1'b1, csc_pkg::OFF_IRQ_STAT, 32'h7);
    repeat (100) @(posedge hclk);
    rdchk(csc_pkg::OFF_CTRL, 32'h3);
    rdchk(csc_pkg::OFF_IRQ_STAT, 32'h1);
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h0);
    // the engine parks one cycle after enable falls
    @(posedge hclk);
    rdchk(csc_pkg::OFF_CTRL, 32'h0);
    check(32'({afe.enable, afe.chan_sel}), 32'h0);
    // shorted channels measured as one node
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h1);
    xfer(1'b1, csc_pkg::OFF_CFG, 32'h0);
    xfer(1'b1, csc_pkg::OFF_SCAN, 32'h5);
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h9);
    @(posedge hclk);
    check(32'(afe.chan_sel), 32'h5);
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'hb);
    wait_idle();
    rdchk(csc_pkg::OFF_RESULT, 32'((cap(0) + cap(2)) & 16'hfff8));
    // single scan of channels 1 and 2, end-of-scan status
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h1);
    xfer(1'b1, csc_pkg::OFF_CFG, 32'h50);
    xfer(1'b1, csc_pkg::OFF_SCAN, 32'h6);
    xfer(1'b1, csc_pkg::OFF_THRESH, 32'hffff);
    xfer(1'b1, csc_pkg::OFF_IRQ_STAT, 32'h7);
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h3);
    wait_idle();
    rdchk(csc_pkg::OFF_RESULT, 32'(cap(2) & 16'hfff8));
    xfer(1'b0, csc_pkg::OFF_IRQ_STAT, 32'h0);
    check(32'(rd[csc_pkg::IRQ_EOS]), 32'h1);
    // auto-scan stops on the greater flag
    xfer(1'b1, csc_pkg::OFF_CFG, 32'h70);
    xfer(1'b1, csc_pkg::OFF_THRESH, 32'h0);
    xfer(1'b1, csc_pkg::OFF_CTRL, 32'h3);
    wait_idle();
    check(rd, 32'h5);
    repeat (150) @(posedge hclk);
    rdchk(csc_pkg::OFF_CTRL, 32'h5);
    rdchk(csc_pkg::OFF_MUX, 32'h1);
    finish_test();
  end
endmodule : test_capacitive_sense_conversion_control

// ---- hdl/csc_pkg.sv ----
// shared constants, types and register map of the capacitive sense control block
package csc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_MODE2 = 8'h08;
  localparam logic [7:0] OFF_SCAN = 8'h0c;
  localparam logic [7:0] OFF_THRESH = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [7:0] OFF_MUX = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  // control register bit positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_BUSY = 1;
  localparam int CTRL_GT = 2;
  localparam int CTRL_MCE = 3;
  localparam int CTRL_SMEN = 4;
  // field positions
  localparam int CFG_ACU_LSB = 0;
  localparam int CFG_SOC_LSB = 4;
  localparam int MODE2_LEN_LSB = 0;
  localparam int MODE2_GAIN_LSB = 4;
  // interrupt status and mask bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_GT = 1;
  localparam int IRQ_EOS = 2;
  // reset values
  localparam logic [1:0] LEN_RST = 2'h1;
  localparam logic [2:0] GAIN_RST = 3'h7;
  localparam logic [2:0] ACU_RST = 3'h0;
  localparam logic [15:0] SCAN_RST = 16'h0000;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [3:0] MUX_RST = 4'h0;
  // timing: one successive-approximation step
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_NS = 32;
  localparam int STEP_CYCLES = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // start-of-conversion sources
  typedef enum logic [2:0] {
    SOC_SW = 3'h0, SOC_T0 = 3'h1, SOC_T2 = 3'h2, SOC_T1 = 3'h3,
    SOC_T3 = 3'h4, SOC_SCAN = 3'h5, SOC_CONT = 3'h6, SOC_AUTO = 3'h7
  } csc_soc_e;
  // conversion engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_CONV = 3'h2, ST_DONE = 3'h4
  } csc_state_e;
  // software configuration
  typedef struct packed {
    logic en;
    logic mce;
    logic smen;
    csc_soc_e soc;
    logic [2:0] acu;
    logic [1:0] len;
    logic [2:0] gain;
    logic [15:0] scan;
    logic [15:0] thresh;
  } csc_cfg_s;
  // analog front-end controls
  typedef struct packed {
    logic enable;
    logic [2:0] gain;
    logic [15:0] chan_sel;
    logic [15:0] trial;
  } csc_afe_s;
endpackage : csc_pkg

// ---- hdl/csc_top.sv ----
// capacitive sense conversion control with ahb-lite register slave
module csc_top #(
  parameter int STEP = csc_pkg::STEP_CYCLES
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write not read
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic [3:0] tmr_ovf, // timer overflow pulses, index = timer
  input wire logic cmp_pin, // analog comparator, asynchronous
  output csc_pkg::csc_afe_s afe, // front-end controls
  output logic irq // level interrupt
);
  csc_pkg::csc_cfg_s cfg_r, cfg_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] adr_r, adr_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  csc_pkg::csc_state_e st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] code_r, code_nxt;
  logic [21:0] acc_r, acc_nxt;
  logic [5:0] acnt_r, acnt_nxt;
  logic run_r, run_nxt;
  logic [15:0] pend_r, pend_nxt;
  logic [3:0] mux_r, mux_nxt;
  logic [15:0] res_r, res_nxt;
  logic gt_r, gt_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [2:0] sync_r;
  logic cmp_r;
  logic busy;
  logic wr_ctrl, wr_mux, wr_stat, busy_wr;
  logic [3:0] lsb_idx;
  logic [5:0] n_m1;
  logic [2:0] shift;
  logic acc_last;
  logic [21:0] acc_sum;
  logic [15:0] quot;
  logic [15:0] trial;
  logic [15:0] low_mask;

  // lowest enabled channel after cur, wrapping; cur itself if it is the only one
  function automatic logic [3:0] csc_next(input logic [15:0] m, input logic [3:0] cur);
    logic [3:0] idx;
    logic [3:0] res;
    logic hit;
    res = cur;
    hit = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      idx = cur + 4'(i);
      if (!hit && m[idx]) begin
        res = idx;
        hit = 1'b1;
      end
    end
    return res;
  endfunction : csc_next

  // comparator pin: three flops, accepted once the last two agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_r <= 3'h0;
      cmp_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], cmp_pin};
      if (sync_r[1] == sync_r[2]) begin
        cmp_r <= sync_r[2];
      end
    end
  end

  // length, accumulate count and divider decode
  always_comb begin
    case (cfg_r.len)
      2'h0: lsb_idx = 4'h4;
      2'h1: lsb_idx = 4'h3;
      2'h2: lsb_idx = 4'h2;
      default: lsb_idx = 4'h0;
    endcase
    case (cfg_r.acu)
      3'h0: begin n_m1 = 6'h00; shift = 3'h0; end
      3'h1: begin n_m1 = 6'h03; shift = 3'h2; end
      3'h2: begin n_m1 = 6'h07; shift = 3'h3; end
      3'h3: begin n_m1 = 6'h0f; shift = 3'h4; end
      3'h4: begin n_m1 = 6'h1f; shift = 3'h5; end
      default: begin n_m1 = 6'h3f; shift = 3'h6; end
    endcase
  end

  assign busy = (st_r != csc_pkg::ST_IDLE);
  assign acc_last = (acnt_r == n_m1);
  assign acc_sum = acc_r + {6'h00, code_r};
  assign quot = 16'(acc_sum >> shift);
  assign trial = code_r | (16'h0001 << bit_r);
  assign low_mask = 16'((17'h00001 << lsb_idx) - 17'h00001);
  assign wr_ctrl = wr_r && (adr_r == csc_pkg::OFF_CTRL);
  assign wr_mux = wr_r && (adr_r == csc_pkg::OFF_MUX);
  assign wr_stat = wr_r && (adr_r == csc_pkg::OFF_IRQ_STAT);
  assign busy_wr = wr_ctrl && hwdata[csc_pkg::CTRL_BUSY] && hwdata[csc_pkg::CTRL_EN];

  // bus slave: zero wait states, okay always; read data captured in the address phase
  always_comb begin
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    wr_nxt = hsel && hready && htrans[1] && hwrite;
    adr_nxt = hsel && hready && htrans[1] ? {haddr[7:2], 2'h0} : adr_r;
    rdat_nxt = rdat_r;
    if (wr_r) begin
      case (adr_r)
        csc_pkg::OFF_CTRL: begin
          cfg_nxt.en = hwdata[csc_pkg::CTRL_EN];
          cfg_nxt.mce = hwdata[csc_pkg::CTRL_MCE];
          cfg_nxt.smen = hwdata[csc_pkg::CTRL_SMEN];
        end
        csc_pkg::OFF_CFG: begin
          cfg_nxt.soc = csc_pkg::csc_soc_e'(hwdata[csc_pkg::CFG_SOC_LSB +: 3]);
          cfg_nxt.acu = hwdata[csc_pkg::CFG_ACU_LSB +: 3];
        end
        csc_pkg::OFF_MODE2: begin
          cfg_nxt.len = hwdata[csc_pkg::MODE2_LEN_LSB +: 2];
          cfg_nxt.gain = hwdata[csc_pkg::MODE2_GAIN_LSB +: 3];
        end
        csc_pkg::OFF_SCAN: cfg_nxt.scan = hwdata[15:0];
        csc_pkg::OFF_THRESH: cfg_nxt.thresh = hwdata[15:0];
        csc_pkg::OFF_IRQ_MASK: mask_nxt = hwdata[2:0];
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      case ({haddr[7:2], 2'h0})
        csc_pkg::OFF_CTRL: rdat_nxt = {27'h0, cfg_r.smen, cfg_r.mce, gt_r, busy, cfg_r.en};
        csc_pkg::OFF_CFG: rdat_nxt = {25'h0, cfg_r.soc, 1'b0, cfg_r.acu};
        csc_pkg::OFF_MODE2: rdat_nxt = {25'h0, cfg_r.gain, 2'h0, cfg_r.len};
        csc_pkg::OFF_SCAN: rdat_nxt = {16'h0, cfg_r.scan};
        csc_pkg::OFF_THRESH: rdat_nxt = {16'h0, cfg_r.thresh};
        csc_pkg::OFF_RESULT: rdat_nxt = {16'h0, res_r};
        csc_pkg::OFF_MUX: rdat_nxt = {28'h0, mux_r};
        csc_pkg::OFF_IRQ_STAT: rdat_nxt = {29'h0, stat_r};
        csc_pkg::OFF_IRQ_MASK: rdat_nxt = {29'h0, mask_r};
        default: rdat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= '{en: 1'b0, mce: 1'b0, smen: 1'b0, soc: csc_pkg::SOC_SW,
                 acu: csc_pkg::ACU_RST, len: csc_pkg::LEN_RST, gain: csc_pkg::GAIN_RST,
                 scan: csc_pkg::SCAN_RST, thresh: csc_pkg::THRESH_RST};
      mask_r <= 3'h0;
      wr_r <= 1'b0;
      adr_r <= 8'h00;
      rdat_r <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
      wr_r <= wr_nxt;
      adr_r <= adr_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // conversion engine: trigger, bit steps, accumulation, scan stepping, status
  always_comb begin
    logic trig;
    logic [15:0] pm;
    trig = 1'b0;
    pm = 16'h0;
    st_nxt = st_r;
    bit_nxt = bit_r;
    cnt_nxt = cnt_r;
    code_nxt = code_r;
    acc_nxt = acc_r;
    acnt_nxt = acnt_r;
    run_nxt = run_r;
    pend_nxt = pend_r;
    mux_nxt = wr_mux && !busy ? hwdata[3:0] : mux_r;
    res_nxt = res_r;
    gt_nxt = gt_r;
    stat_nxt = wr_stat ? stat_r & ~hwdata[2:0] : stat_r;
    case (st_r)
      csc_pkg::ST_IDLE: begin
        case (cfg_r.soc)
          csc_pkg::SOC_SW: trig = busy_wr;
          csc_pkg::SOC_T0: trig = tmr_ovf[0];
          csc_pkg::SOC_T2: trig = tmr_ovf[2];
          csc_pkg::SOC_T1: trig = tmr_ovf[1];
          csc_pkg::SOC_T3: trig = tmr_ovf[3];
          default: trig = run_r;
        endcase
        if (busy_wr && (cfg_r.soc == csc_pkg::SOC_CONT || cfg_r.soc == csc_pkg::SOC_AUTO)) begin
          run_nxt = 1'b1;
        end
        // single scan resumes where a touch stopped it, else starts a fresh pass
        if (busy_wr && cfg_r.soc == csc_pkg::SOC_SCAN) begin
          pm = (pend_r == 16'h0) ? cfg_r.scan : pend_r;
          pend_nxt = pm;
          run_nxt = (pm != 16'h0);
          mux_nxt = csc_next(pm, (pend_r == 16'h0) ? 4'hf : mux_r);
        end
        if (trig) begin
          st_nxt = csc_pkg::ST_CONV;
          bit_nxt = 4'hf;
          cnt_nxt = 8'h00;
          code_nxt = 16'h0;
          acc_nxt = 22'h0;
          acnt_nxt = 6'h00;
        end
      end
      csc_pkg::ST_CONV: begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == 8'(STEP - 1)) begin
          cnt_nxt = 8'h00;
          code_nxt = cmp_r ? trial : code_r;
          if (bit_r == lsb_idx) begin
            st_nxt = csc_pkg::ST_DONE; // lower bits never set, stay zero
          end else begin
            bit_nxt = bit_r - 4'h1;
          end
        end
      end
      csc_pkg::ST_DONE: begin
        st_nxt = csc_pkg::ST_CONV;
        bit_nxt = 4'hf;
        code_nxt = 16'h0;
        if (!acc_last) begin
          acc_nxt = acc_sum;
          acnt_nxt = acnt_r + 6'h01;
        end else begin
          acc_nxt = 22'h0;
          acnt_nxt = 6'h00;
          res_nxt = quot;
          gt_nxt = quot > cfg_r.thresh;
          stat_nxt[csc_pkg::IRQ_DONE] = 1'b1;
          if (quot > cfg_r.thresh) begin
            stat_nxt[csc_pkg::IRQ_GT] = 1'b1;
          end
          if (cfg_r.soc == csc_pkg::SOC_AUTO) begin
            mux_nxt = csc_next(cfg_r.scan, mux_r);
            if (quot > cfg_r.thresh) begin
              run_nxt = 1'b0;
            end
          end
          if (cfg_r.soc == csc_pkg::SOC_SCAN) begin
            pm = pend_r & ~(16'h0001 << mux_r);
            pend_nxt = pm;
            if (pm == 16'h0) begin
              stat_nxt[csc_pkg::IRQ_EOS] = 1'b1;
              run_nxt = 1'b0;
            end else if (quot > cfg_r.thresh) begin
              run_nxt = 1'b0; // touch stops the pass on this channel
            end else begin
              mux_nxt = csc_next(pm, mux_r);
            end
          end
          if (!(cfg_r.soc inside {csc_pkg::SOC_CONT, csc_pkg::SOC_AUTO, csc_pkg::SOC_SCAN})) begin
            st_nxt = csc_pkg::ST_IDLE;
          end else if (!run_nxt) begin
            st_nxt = csc_pkg::ST_IDLE;
          end
        end
      end
      default: st_nxt = csc_pkg::ST_IDLE;
    endcase
    // disable aborts everything and parks the engine
    if (!cfg_r.en) begin
      st_nxt = csc_pkg::ST_IDLE;
      run_nxt = 1'b0;
      pend_nxt = 16'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= csc_pkg::ST_IDLE;
      bit_r <= 4'hf;
      cnt_r <= 8'h00;
      code_r <= 16'h0;
      acc_r <= 22'h0;
      acnt_r <= 6'h00;
      run_r <= 1'b0;
      pend_r <= 16'h0;
      mux_r <= csc_pkg::MUX_RST;
      res_r <= 16'h0;
      gt_r <= 1'b0;
      stat_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      acc_r <= acc_nxt;
      acnt_r <= acnt_nxt;
      run_r <= run_nxt;
      pend_r <= pend_nxt;
      mux_r <= mux_nxt;
      res_r <= res_nxt;
      gt_r <= gt_nxt;
      stat_r <= stat_nxt;
    end
  end

  // outputs; shorted group replaces the single channel when multi-channel is on
  assign afe.enable = cfg_r.en;
  assign afe.gain = cfg_r.gain;
  assign afe.chan_sel = !cfg_r.en ? 16'h0 : cfg_r.mce ? cfg_r.scan : 16'h0001 << mux_r;
  assign afe.trial = (st_r == csc_pkg::ST_CONV) ? trial : code_r;
  assign irq = |(stat_r & mask_r);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdat_r;

  sequence s_final;
    st_r == csc_pkg::ST_DONE && acc_last;
  endsequence
  property p_off_idle;
    @(posedge hclk) disable iff (!hresetn) !cfg_r.en |=> st_r == csc_pkg::ST_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("engine active while disabled");
  property p_sw_start;
    @(posedge hclk) disable iff (!hresetn)
      st_r == csc_pkg::ST_IDLE && cfg_r.en && cfg_r.soc == csc_pkg::SOC_SW && busy_wr
      |=> st_r == csc_pkg::ST_CONV ##1 busy;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start not taken");
  property p_cont_wait;
    @(posedge hclk) disable iff (!hresetn)
      st_r == csc_pkg::ST_IDLE && cfg_r.soc == csc_pkg::SOC_CONT && !run_r && !busy_wr
      |=> st_r == csc_pkg::ST_IDLE;
  endproperty
  a_cont_wait: assert property (p_cont_wait) else $error("continuous start without busy");
  property p_done_irq;
    @(posedge hclk) disable iff (!hresetn) s_final and cfg_r.en |=> stat_r[csc_pkg::IRQ_DONE];
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("complete flag not set");
  property p_acc_quiet;
    @(posedge hclk) disable iff (!hresetn)
      st_r == csc_pkg::ST_DONE && !acc_last && !stat_r[csc_pkg::IRQ_DONE]
      |=> !stat_r[csc_pkg::IRQ_DONE];
  endproperty
  a_acc_quiet: assert property (p_acc_quiet) else $error("complete flag mid accumulation");
  property p_low_zero;
    @(posedge hclk) disable iff (!hresetn) st_r == csc_pkg::ST_DONE |-> (code_r & low_mask) == 16'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("unconverted bits not zero");
  property p_gt_flag;
    @(posedge hclk) disable iff (!hresetn)
      s_final and cfg_r.en |=> gt_r == (res_r > cfg_r.thresh) && res_r == $past(quot);
  endproperty
  a_gt_flag: assert property (p_gt_flag) else $error("greater flag or result wrong");
  property p_auto_stop;
    @(posedge hclk) disable iff (!hresetn)
      s_final and cfg_r.soc == csc_pkg::SOC_AUTO && quot > cfg_r.thresh |=> !run_r;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("auto-scan kept running");
  property p_multi;
    @(posedge hclk) disable iff (!hresetn) cfg_r.en && cfg_r.mce |-> afe.chan_sel == cfg_r.scan;
  endproperty
  a_multi: assert property (p_multi) else $error("channels not shorted");
  property p_tmr_ignored;
    @(posedge hclk) disable iff (!hresetn)
      cfg_r.en && st_r == csc_pkg::ST_CONV && cnt_r != 8'(STEP - 1)
      |=> st_r == csc_pkg::ST_CONV && cnt_r != 8'h00;
  endproperty
  a_tmr_ignored: assert property (p_tmr_ignored) else $error("conversion restarted");
endmodule : csc_top
